// *** core/sesp_pkg.sv ***
package sesp_pkg;

    // ****************************************************************
    // opcodes
    // ****************************************************************
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_READ = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;

    // ****************************************************************
    // frame geometry, in serial clock rising edges
    // ****************************************************************
    localparam int BYTE_BITS = 8;
    localparam logic [4:0] EDGE_OPCODE_LAST = 5'h07;
    localparam logic [4:0] EDGE_DATA_LAST = 5'h0f;
    localparam logic [4:0] EDGE_SATURATE = 5'h1f;

    // ****************************************************************
    // status register layout and reset
    // ****************************************************************
    localparam int BIT_LOCK = 7;
    localparam int BIT_SIZE_HI = 3;
    localparam int BIT_SIZE_LO = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef struct packed {
        logic lock_enable;
        logic [2:0] zero;
        logic size_hi;
        logic size_lo;
        logic latch;
        logic busy;
    } sesp_status_t;

    // ****************************************************************
    // protected area starts, array is 12 address bits
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] AREA_QUARTER = 12'hc00;
    localparam logic [11:0] AREA_HALF = 12'h800;
    localparam logic [11:0] AREA_WHOLE = 12'h000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int SELF_TIMED_US = 4000;
    localparam int TIMER_W = 24;

    // ****************************************************************
    // what a frame asks for if select rises now
    // ****************************************************************
    typedef enum logic [1:0] {
        SESP_KIND_NONE,
        SESP_KIND_SET,
        SESP_KIND_CLR,
        SESP_KIND_WRITE
    } sesp_kind_t;

    typedef struct packed {
        sesp_kind_t kind;
        logic [7:0] data;
        logic seq;
    } sesp_frame_t;

endpackage

// *** core/sesp_status_protect.sv ***
`timescale 1ns/1ps
// What this block does
// - latch set only by set-latch opcode
// - latch opcodes act when select rises while idle
// - latch clears: reset, clear, write completions
// - status read anytime, repeats while selected
// - busy bit high during self-timed cycle
// - latch low rejects status and array writes
// - size bits kept, guard array writes
// - lock bit plus low pin blocks status writes
// - status write needs exactly opcode plus byte
// - select rise while idle starts timed cycle, busy
// - new status bits apply after cycle ends
// - only bits 7,3,2 writable, 6-4 zero
// - lock bit zero: pin level ignored
// - lock bit one, pin high: writes allowed
// - pin lock entered either order, pin exits
// - pin lock keeps area, others writable
// - size code selects quarter, half, whole
// - four single-byte opcodes decoded
module sesp_status_protect #(
    parameter int SELF_TIMED_CYCLES =
        sesp_pkg::SELF_TIMED_US * (sesp_pkg::CLK_HZ / 1000000)
) (
    // system clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // serial link, the serial clock is a domain of its own
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_d_in,
    output logic spi_q_out,
    output logic spi_q_oe_out,
    // write-protect pin
    input wire logic hard_lock_pin_n_in,
    // array write requests from the array logic
    input wire logic array_wr_req_in,
    input wire logic [sesp_pkg::ADDR_W-1:0] array_wr_addr_in,
    output logic array_wr_grant_out,
    output logic array_wr_reject_out,
    // status view
    output logic [7:0] status_out,
    output logic pin_lock_mode_out
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (SELF_TIMED_CYCLES < 1 ||
        SELF_TIMED_CYCLES >= (1 << sesp_pkg::TIMER_W)) begin : g_chk
        $error("self-timed cycle count out of range");
    end

    localparam logic [sesp_pkg::TIMER_W-1:0] TIMER_LAST =
        sesp_pkg::TIMER_W'(SELF_TIMED_CYCLES - 1);

    // ****************************************************************
    // link domain: capture opcode and data on rising edges
    // ****************************************************************
    logic [4:0] edge_cnt;
    logic [7:0] in_sh;
    logic [7:0] opcode;
    logic rd_active;
    logic [4:0] next_edge_cnt;
    logic [7:0] next_in_sh;
    logic [7:0] next_opcode;
    logic next_rd_active;
    sesp_pkg::sesp_frame_t frame;
    sesp_pkg::sesp_frame_t next_frame;
    logic [7:0] stat_l1;
    logic [7:0] stat_l2;

    // decide what the frame means if select were raised right now
    always_comb begin
        logic [7:0] word;
        word = {in_sh[6:0], spi_d_in};
        next_in_sh = word;
        next_opcode = opcode;
        next_rd_active = rd_active;
        next_frame = frame;
        next_frame.kind = sesp_pkg::SESP_KIND_NONE;
        next_edge_cnt = (edge_cnt == sesp_pkg::EDGE_SATURATE) ?
            edge_cnt : edge_cnt + 5'h01;
        // a new frame flips the sequence bit so stale kinds never replay
        if (edge_cnt == 5'h00) begin
            next_frame.seq = ~frame.seq;
        end
        if (edge_cnt == sesp_pkg::EDGE_OPCODE_LAST) begin
            next_opcode = word;
            unique case (word)
                sesp_pkg::OP_SET_LATCH:
                    next_frame.kind = sesp_pkg::SESP_KIND_SET;
                sesp_pkg::OP_CLR_LATCH:
                    next_frame.kind = sesp_pkg::SESP_KIND_CLR;
                sesp_pkg::OP_STAT_READ:
                    next_rd_active = 1'b1;
                default:
                    next_frame.kind = sesp_pkg::SESP_KIND_NONE;
            endcase
        end
        // only a write whose last data bit is the latest edge counts
        if (edge_cnt == sesp_pkg::EDGE_DATA_LAST &&
            opcode == sesp_pkg::OP_STAT_WRITE) begin
            next_frame.kind = sesp_pkg::SESP_KIND_WRITE;
            next_frame.data = word;
        end
    end

    // edge count and read flag restart whenever select is high
    always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            edge_cnt <= 5'h00;
            rd_active <= 1'b0;
        end else begin
            edge_cnt <= next_edge_cnt;
            rd_active <= next_rd_active;
        end
    end

    // frame result survives deselect so the system side can read it
    always_ff @(posedge spi_clk_in or posedge rst_in) begin
        if (rst_in) begin
            in_sh <= 8'h00;
            opcode <= 8'h00;
            frame <= '0;
            stat_l1 <= sesp_pkg::STATUS_RESET;
            stat_l2 <= sesp_pkg::STATUS_RESET;
        end else begin
            in_sh <= next_in_sh;
            opcode <= next_opcode;
            frame <= next_frame;
            stat_l1 <= status_out;
            stat_l2 <= stat_l1;
        end
    end

    // ****************************************************************
    // link domain: status shift-out on falling edges
    // ****************************************************************
    logic [2:0] tx_cnt;
    logic [7:0] tx_sh;
    logic [2:0] next_tx_cnt;
    logic [7:0] next_tx_sh;
    logic next_q;
    logic next_q_oe;

    // the status copy is resampled each byte, so busy polling stays fresh
    always_comb begin
        logic [7:0] cur;
        cur = (tx_cnt == 3'h0) ? stat_l2 : tx_sh;
        next_tx_sh = cur;
        next_tx_cnt = tx_cnt;
        next_q = spi_q_out;
        next_q_oe = spi_q_oe_out;
        if (rd_active) begin
            next_q = cur[3'h7 - tx_cnt];
            next_q_oe = 1'b1;
            next_tx_cnt = tx_cnt + 3'h1;
        end
    end

    always_ff @(negedge spi_clk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            tx_cnt <= 3'h0;
            tx_sh <= 8'h00;
            spi_q_out <= 1'b0;
            spi_q_oe_out <= 1'b0;
        end else begin
            tx_cnt <= next_tx_cnt;
            tx_sh <= next_tx_sh;
            spi_q_out <= next_q;
            spi_q_oe_out <= next_q_oe;
        end
    end

    // ****************************************************************
    // system domain: synchronisers
    // ****************************************************************
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic lock_s1;
    logic lock_s2;

    // reset to the idle select level so no false rise follows reset
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            lock_s1 <= 1'b1;
            lock_s2 <= 1'b1;
        end else begin
            cs_s1 <= spi_cs_n_in;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            lock_s1 <= hard_lock_pin_n_in;
            lock_s2 <= lock_s1;
        end
    end

    // ****************************************************************
    // system domain: status register and self-timed cycle
    // ****************************************************************
    typedef enum logic [1:0] {
        SESP_IDLE,
        SESP_BUSY_STATUS,
        SESP_BUSY_ARRAY
    } sesp_state_t;

    sesp_state_t state;
    sesp_state_t next_state;
    logic [sesp_pkg::TIMER_W-1:0] timer;
    logic [sesp_pkg::TIMER_W-1:0] next_timer;
    sesp_pkg::sesp_status_t stat;
    sesp_pkg::sesp_status_t next_stat;
    logic [7:0] pend;
    logic [7:0] next_pend;
    logic seen_seq;
    logic next_seen_seq;
    logic next_grant;
    logic next_reject;
    logic next_pin_lock;
    logic cs_rise;
    logic in_area;

    // frame fields are only read once select has settled high
    assign cs_rise = cs_s2 & ~cs_s3 & (frame.seq != seen_seq);

    // decode of the protected region
    always_comb begin
        unique case ({stat.size_hi, stat.size_lo})
            2'b00: in_area = 1'b0;
            2'b01: in_area = array_wr_addr_in >= sesp_pkg::AREA_QUARTER;
            2'b10: in_area = array_wr_addr_in >= sesp_pkg::AREA_HALF;
            2'b11: in_area = array_wr_addr_in >= sesp_pkg::AREA_WHOLE;
        endcase
    end

    // command execution and timed cycle
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_stat = stat;
        next_pend = pend;
        next_seen_seq = seen_seq;
        next_grant = 1'b0;
        next_reject = 1'b0;
        // pin lock follows lock bit and pin in either order
        next_pin_lock = stat.lock_enable & ~lock_s2;
        if (cs_rise) begin
            next_seen_seq = frame.seq;
        end
        unique case (state)
            SESP_IDLE: begin
                if (cs_rise) begin
                    unique case (frame.kind)
                        sesp_pkg::SESP_KIND_SET:
                            next_stat.latch = 1'b1;
                        sesp_pkg::SESP_KIND_CLR:
                            next_stat.latch = 1'b0;
                        sesp_pkg::SESP_KIND_WRITE: begin
                            if (stat.latch && !pin_lock_mode_out) begin
                                next_pend = frame.data;
                                next_timer = '0;
                                next_state = SESP_BUSY_STATUS;
                            end
                        end
                        sesp_pkg::SESP_KIND_NONE: ;
                    endcase
                end else if (array_wr_req_in) begin
                    // pin lock leaves the area guard unchanged
                    if (stat.latch && !in_area) begin
                        next_grant = 1'b1;
                        next_timer = '0;
                        next_state = SESP_BUSY_ARRAY;
                    end else begin
                        next_reject = 1'b1;
                    end
                end
            end
            SESP_BUSY_STATUS, SESP_BUSY_ARRAY: begin
                // requests during a cycle are refused, host should poll
                next_reject = array_wr_req_in;
                next_timer = timer + 1'b1;
                if (timer == TIMER_LAST) begin
                    next_state = SESP_IDLE;
                    next_stat.latch = 1'b0;
                    if (state == SESP_BUSY_STATUS) begin
                        // only lock and size bits are taken
                        next_stat.lock_enable =
                            pend[sesp_pkg::BIT_LOCK];
                        next_stat.size_hi = pend[sesp_pkg::BIT_SIZE_HI];
                        next_stat.size_lo = pend[sesp_pkg::BIT_SIZE_LO];
                    end
                end
            end
        endcase
        next_stat.zero = 3'h0;
        next_stat.busy = (next_state != SESP_IDLE);
    end

    // size and lock bits stand in for non-volatile cells here
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= SESP_IDLE;
            timer <= '0;
            stat <= sesp_pkg::STATUS_RESET;
            pend <= 8'h00;
            seen_seq <= 1'b0;
            array_wr_grant_out <= 1'b0;
            array_wr_reject_out <= 1'b0;
            pin_lock_mode_out <= 1'b0;
            status_out <= sesp_pkg::STATUS_RESET;
        end else begin
            state <= next_state;
            timer <= next_timer;
            stat <= next_stat;
            pend <= next_pend;
            seen_seq <= next_seen_seq;
            array_wr_grant_out <= next_grant;
            array_wr_reject_out <= next_reject;
            pin_lock_mode_out <= next_pin_lock;
            status_out <= next_stat;
        end
    end

endmodule // sesp_status_protect

// *** test/sesp_host_model.sv ***
`timescale 1ns/1ps
// ****
// serial host, clock idles low between frames
// ****
module sesp_host_model (
    // serial pins
    output logic spi_clk_out,
    output logic spi_cs_n_out,
    output logic spi_d_out,
    input wire logic spi_q_in
);
    // idle levels at time zero
    initial begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_d_out = 1'b0;
    end

    // n bits of w msb first, q captured on each rise
    task automatic xfer(input logic [23:0] w, input int n,
                        output logic [15:0] rd);
        rd = 16'h0000;
        #7 spi_cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_d_out = w[23-i];
            #15 spi_clk_out = 1'b1;
            rd = {rd[14:0], spi_q_in};
            #15 spi_clk_out = 1'b0;
        end
        // select rises between the last rise and the next one
        #10 spi_cs_n_out = 1'b1;
        spi_d_out = ~spi_d_out;
    endtask
endmodule // sesp_host_model

// *** test/sesp_status_protect_checker.sv ***
`timescale 1ns/1ps
// ****
// port checker
// ****
module sesp_status_protect_checker #(
    parameter int SELF_TIMED_CYCLES = 20
) (
    // system side
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // serial link
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_d_in,
    input wire logic spi_q_out,
    input wire logic spi_q_oe_out,
    // pin and array side
    input wire logic hard_lock_pin_n_in,
    input wire logic array_wr_req_in,
    input wire logic [sesp_pkg::ADDR_W-1:0] array_wr_addr_in,
    input wire logic array_wr_grant_out,
    input wire logic array_wr_reject_out,
    // status view
    input wire logic [7:0] status_out,
    input wire logic pin_lock_mode_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // size code guards this address
    function automatic logic guarded(input logic [11:0] a,
                                     input logic [1:0] s);
        return s == 2'h3 || (s == 2'h2 && a[11]) ||
               (s == 2'h1 && a[11:10] == 2'h3);
    endfunction

    AST_RESET_ZERO: assert property ($fell(rst_in) |-> !status_out)
        else $error("status not clear after reset");
    AST_ZERO_BITS: assert property (status_out[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    AST_PIN_ENTER: assert property (
        (status_out[7] && !hard_lock_pin_n_in) [*5] |-> pin_lock_mode_out)
        else $error("pin lock mode not entered");
    AST_PIN_EXIT: assert property (
        hard_lock_pin_n_in [*5] |-> !pin_lock_mode_out)
        else $error("pin lock mode kept with pin high");
    AST_GRANT_LATCH: assert property (array_wr_grant_out |->
        $past(status_out[1]) && !$past(status_out[0]))
        else $error("grant without latch or while busy");
    AST_GRANT_BUSY: assert property (
        array_wr_grant_out |-> ##[0:1] status_out[0])
        else $error("grant did not raise busy");
    AST_ANSWER_CAUSE: assert property (
        (array_wr_grant_out || array_wr_reject_out) |->
        $past(array_wr_req_in) && !(array_wr_grant_out && array_wr_reject_out))
        else $error("array answer without request");
    AST_PROTECT: assert property (array_wr_grant_out |->
        !guarded($past(array_wr_addr_in), $past(status_out[3:2])))
        else $error("grant inside protected area");
    AST_BUSY_HOLD: assert property (
        $rose(status_out[0]) |-> status_out[0] [*8])
        else $error("busy dropped early");
    AST_Q_IDLE: assert property (spi_cs_n_in |-> !spi_q_oe_out)
        else $error("output driven while deselected");

    // main scenarios reached
    COV_GRANT: cover property (array_wr_grant_out);
    COV_REJECT: cover property (array_wr_reject_out);
    COV_PIN: cover property ($rose(pin_lock_mode_out));
endmodule // sesp_status_protect_checker

bind sesp_status_protect sesp_status_protect_checker #(
    .SELF_TIMED_CYCLES(SELF_TIMED_CYCLES)
) u_chk (
    .clk_sys_in, .rst_in, .spi_clk_in, .spi_cs_n_in, .spi_d_in,
    .spi_q_out, .spi_q_oe_out, .hard_lock_pin_n_in, .array_wr_req_in,
    .array_wr_addr_in, .array_wr_grant_out, .array_wr_reject_out,
    .status_out, .pin_lock_mode_out
);

// *** test/test_spi_eeprom_status_protect.sv ***
`timescale 1ns/1ps
module test_spi_eeprom_status_protect;
    // ****
    // signals and model state
    // ****
    localparam int CYC = 40;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic spi_clk_in, spi_cs_n_in, spi_d_in, spi_q_out, spi_q_oe_out;
    logic hard_lock_pin_n_in = 1'b1;
    logic array_wr_req_in = 1'b0;
    logic [11:0] array_wr_addr_in = 12'h000;
    logic array_wr_grant_out, array_wr_reject_out, pin_lock_mode_out;
    logic [7:0] status_out;
    logic [15:0] rd;
    logic [31:0] seed = 32'hb8b7;
    logic [11:0] at [7] = '{12'h000, 12'h7ff, 12'h800, 12'hbff, 12'hc00,
                            12'hfff, 12'h000};
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] m_nv = 8'h00;
    logic m_latch = 1'b0;

    sesp_status_protect #(.SELF_TIMED_CYCLES(CYC)) DUT (
        .clk_sys_in, .rst_in, .spi_clk_in, .spi_cs_n_in, .spi_d_in,
        .spi_q_out, .spi_q_oe_out, .hard_lock_pin_n_in, .array_wr_req_in,
        .array_wr_addr_in, .array_wr_grant_out, .array_wr_reject_out,
        .status_out, .pin_lock_mode_out
    );
    sesp_host_model host (
        .spi_clk_out(spi_clk_in), .spi_cs_n_out(spi_cs_n_in),
        .spi_d_out(spi_d_in), .spi_q_in(spi_q_out)
    );

    // 50 ns system clock, hang guard well above the run length
    always #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ****
    // helpers
    // ****
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] st();
        return m_nv | {6'h00, m_latch, 1'b0};
    endfunction
    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // bounded poll of the busy bit, the host's duty while a cycle runs
    task automatic wait_idle();
        for (int k = 0; k < 200 && status_out[0] !== 1'b0; k++)
            ticks(1);
    endtask
    task automatic cmd(input logic [7:0] op, input logic l);
        host.xfer({op, 16'h0000}, 8, rd);
        ticks(6);
        m_latch = l;
        cmp("latch", st(), status_out);
    endtask
    task automatic set_write_latch_cmd();
        cmd(sesp_pkg::OP_SET_LATCH, 1'b1);
    endtask
    // two passes of the status byte within one frame
    task automatic status_read_cmd(input logic [7:0] exp);
        host.xfer({sesp_pkg::OP_STAT_READ, 16'haaaa}, 24, rd);
        ticks(6);
        cmp("read0", exp, rd[15:8]);
        cmp("read1", exp, rd[7:0]);
    endtask
    task automatic status_write_cmd(input logic [7:0] d, input int n);
        logic ok;
        ok = m_latch && n == 16 && !(m_nv[7] && !hard_lock_pin_n_in);
        host.xfer({sesp_pkg::OP_STAT_WRITE, d, 8'h00}, n, rd);
        ticks(6);
        cmp("busy", 8'(ok), 8'(status_out[0]));
        if (ok) begin
            status_read_cmd(st() | 8'h01);
            wait_idle();
            m_nv = d & 8'h8c;
            m_latch = 1'b0;
        end
        cmp("status", st(), status_out);
    endtask
    // grant may land one or two edges after the request
    task automatic arr(input logic [11:0] a);
        logic [1:0] g;
        logic [12:0] lo;
        logic ok;
        lo = (m_nv[3:2] == 2'h3) ? 13'h0 : 13'h1000 - {m_nv[3:2], 10'h0};
        ok = m_latch && {1'b0, a} < lo;
        array_wr_addr_in = a;
        array_wr_req_in = 1'b1;
        ticks(1);
        array_wr_req_in = 1'b0;
        g = {array_wr_reject_out, array_wr_grant_out};
        ticks(1);
        g = g | {array_wr_reject_out, array_wr_grant_out};
        cmp("array", ok ? 8'h01 : 8'h02, {6'h00, g});
        if (ok) begin
            wait_idle();
            m_latch = 1'b0;
        end
        cmp("status", st(), status_out);
    endtask
    task automatic pin(input logic l);
        hard_lock_pin_n_in = l;
        ticks(6);
        cmp("pin_lock", 8'(m_nv[7] & ~l), 8'(pin_lock_mode_out));
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        ticks(4);
        rst_in = 1'b0;
        ticks(2);
        cmp("reset", 8'h00, status_out);
        status_write_cmd(8'h8c, 16);
        arr(12'h000);
        set_write_latch_cmd();
        cmd(sesp_pkg::OP_CLR_LATCH, 1'b0);
        set_write_latch_cmd();
        status_write_cmd(8'h8c, 15);
        // every size code, edges of each area, junk in fixed bits
        for (int s = 0; s < 4; s++) begin
            status_write_cmd(8'(s << 2) | 8'(rnd() & 32'h73), 16);
            at[6] = 12'(rnd());
            foreach (at[i]) begin
                set_write_latch_cmd();
                arr(at[i]);
            end
            set_write_latch_cmd();
        end
        status_write_cmd(8'h84, 16);
        pin(1'b0);
        set_write_latch_cmd();
        status_write_cmd(8'h00, 16);
        arr(12'h3ff);
        set_write_latch_cmd();
        arr(12'hc00);
        pin(1'b1);
        status_write_cmd(8'h00, 16);
        pin(1'b0);
        set_write_latch_cmd();
        status_write_cmd(8'h80, 16);
        pin(1'b0);
        report_and_stop();
    end
endmodule // test_spi_eeprom_status_protect
